// >>> hdl/pbmc_control.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Hardware mode, negotiation strap off: rate from speed strap pin.
// - Hardware mode: status shows active link rate.
// - Software, negotiation on: rate from negotiation.
// - Software, negotiation off: rate bit picks 10/100.
// - Hardware mode: negotiation enable from strap pin.
// - Software: enable bit chooses negotiation or bits.
// - Low power: MAC outputs low, pair tristated.
// - Low-power entry keeps registers, clears latching bits.
// - Any reset loads every register default.
// - Isolate: MAC outputs high-impedance, inputs ignored.
// - Isolate resets to one for address zero.
// - Restart starts negotiation, self-clears when begun.
// - Restart write ignored while negotiation disabled.
// - Hardware mode, negotiation strap off: duplex from duplex strap pin.
// - Hardware mode: status shows active link duplex.
// - Software, negotiation on: duplex from negotiation.
// - Software, negotiation off: duplex bit picks half/full.
// - Loopback makes the duplex bit ineffective.
// - Collision test off: collision ignores transmit enable.
// - Collision test: assert/drop collision in bounds.
// - Reserved low seven bits read zero.
// - Top bit starts self-clearing software reset.
// - Loopback returns transmit data to receive side.
module pbmc_control
   import pbmc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [4:0] phy_addr,
   input wire logic strap_config_source_pin,
   input wire logic speed_strap_pin,
   input wire logic negotiation_strap_pin,
   input wire logic duplex_strap_pin,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic neg_speed_100,
   input wire logic neg_full_duplex,
   input wire logic neg_started,
   output logic neg_restart,
   input wire pbmc_pkg::pbmc_mac_tx_t mac_tx,
   input wire pbmc_pkg::pbmc_mac_rx_t line_rx,
   input wire logic line_tx_clk,
   input wire logic line_rx_clk,
   output pbmc_pkg::pbmc_mac_rx_t mac_rx,
   output logic mac_tx_clk,
   output logic mac_rx_clk,
   output logic mac_out_en,
   output pbmc_pkg::pbmc_mac_tx_t line_tx,
   output logic pair_transmit_tristate,
   output logic pair_receive_enable,
   output logic latch_clear,
   output logic soft_reset_active,
   output pbmc_pkg::pbmc_mode_t mode,
   output logic [1:0] link_status
);
   import pbmc_pkg::*;

   // ---------------------------------------------------------------
   // Shared decodes
   // ---------------------------------------------------------------
   // True while the MAC side must be silent: low power or isolate.
   function automatic logic mac_silent(input logic [15:0] c);
      return c[BIT_LOW_POWER] || c[BIT_ISOLATE];
   endfunction

   // True while the twisted-pair front end is switched off.
   function automatic logic pair_off(input logic [15:0] c);
      return c[BIT_LOW_POWER] || c[BIT_LOOPBACK];
   endfunction

   // ---------------------------------------------------------------
   // Control register and software reset
   // ---------------------------------------------------------------
   logic [15:0] ctrl_q, ctrl_d;
   pbmc_state_t state_q, state_d;
   logic [3:0] srst_cnt_q, srst_cnt_d;
   logic iso_init_q, iso_init_d;

   // The isolate default depends on the management address, so the reset word is built here.
   // Software reset reloads the same word, so both kinds of reset agree.
   function automatic logic [15:0] reset_word(input logic [4:0] addr);
      logic [15:0] w;
      w = RESET_VALUE;
      w[BIT_ISOLATE] = (addr == ADDR_ISOLATE_DEFAULT);
      return w;
   endfunction

   always_comb begin
      ctrl_d = ctrl_q;
      state_d = state_q;
      srst_cnt_d = srst_cnt_q;
      iso_init_d = 1'b0;
      // The first clock after reset loads the address-dependent isolate default; a write in that clock is dropped.
      if (iso_init_q) begin
         ctrl_d = reset_word(phy_addr);
      end
      case (state_q)
         PBMC_RUN: begin
            if (reg_wr && !iso_init_q) begin
               ctrl_d = reg_wdata & WRITABLE_MASK;
               // A restart request only sticks if negotiation was and stays enabled.
               if (!reg_wdata[BIT_NEG_EN] || !ctrl_q[BIT_NEG_EN]) begin
                  ctrl_d[BIT_NEG_RESTART] = 1'b0;
               end
               if (reg_wdata[BIT_SOFT_RESET]) begin
                  state_d = PBMC_SRST;
                  srst_cnt_d = SOFT_RESET_CYCLES;
               end
            end else if (neg_started) begin
               // Self-clear once negotiation has begun; a write in the same cycle takes precedence.
               ctrl_d[BIT_NEG_RESTART] = 1'b0;
            end
         end
         PBMC_SRST: begin
            // Management writes are refused while the software reset runs.
            // The count runs down to zero, then the top bit self-clears.
            ctrl_d = reset_word(phy_addr);
            ctrl_d[BIT_SOFT_RESET] = 1'b1;
            if (srst_cnt_q == 4'h0) begin
               ctrl_d[BIT_SOFT_RESET] = 1'b0;
               state_d = PBMC_RUN;
            end else begin
               srst_cnt_d = srst_cnt_q - 4'h1;
            end
         end
         default: begin
            state_d = PBMC_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= RESET_VALUE;
         state_q <= PBMC_RUN;
         srst_cnt_q <= 4'h0;
         iso_init_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         state_q <= state_d;
         srst_cnt_q <= srst_cnt_d;
         iso_init_q <= iso_init_d;
      end
   end

   // ---------------------------------------------------------------
   // Operating mode resolution
   // ---------------------------------------------------------------
   logic hw_mode, lp, iso, lb, ct;
   pbmc_mode_t mode_d, mode_q;
   logic lp_q;

   assign hw_mode = !strap_config_source_pin;
   assign lp = ctrl_q[BIT_LOW_POWER];
   assign iso = ctrl_q[BIT_ISOLATE];
   assign lb = ctrl_q[BIT_LOOPBACK];
   assign ct = ctrl_q[BIT_COL_TEST];

   // The resolved mode is registered so that status and mode outputs come from flip-flops.
   // Hardware mode takes the straps or, with the negotiation strap on, negotiation; software mode takes the register or negotiation.
   always_comb begin
      if (hw_mode) begin
         mode_d.neg_enable = negotiation_strap_pin;
         mode_d.speed_100 = negotiation_strap_pin ? neg_speed_100 : speed_strap_pin;
         mode_d.full_duplex = negotiation_strap_pin ? neg_full_duplex : duplex_strap_pin;
      end else if (ctrl_q[BIT_NEG_EN]) begin
         mode_d.neg_enable = 1'b1;
         mode_d.speed_100 = neg_speed_100;
         mode_d.full_duplex = neg_full_duplex;
      end else begin
         mode_d.neg_enable = 1'b0;
         mode_d.speed_100 = ctrl_q[BIT_RATE];
         mode_d.full_duplex = ctrl_q[BIT_DUPLEX];
      end
      if (lb) begin
         mode_d.full_duplex = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Collision test tracking of transmit enable
   // ---------------------------------------------------------------
   logic [3:0] col_cnt_q, col_cnt_d;
   logic col_test_q, col_test_d;
   logic tx_en_seen;

   // Transmit enable is ignored while the MAC side is isolated or powered down.
   assign tx_en_seen = mac_tx.tx_en && !mac_silent(ctrl_q);

   // Each edge of transmit enable must persist for its count before collision follows.
   always_comb begin
      col_test_d = col_test_q;
      col_cnt_d = col_cnt_q;
      if (!ct || state_q == PBMC_SRST) begin
         col_test_d = 1'b0;
         col_cnt_d = 4'h0;
      end else if (tx_en_seen != col_test_q) begin
         if (col_cnt_q == 4'h0) begin
            col_test_d = tx_en_seen;
         end else begin
            col_cnt_d = col_cnt_q - 4'h1;
         end
      end else begin
         // While transmit enable is steady the counter is reloaded for the next edge.
         col_cnt_d = col_test_q ? COL_DEASSERT_CYCLES - 4'h1 : COL_ASSERT_CYCLES - 4'h1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= '0;
         col_test_q <= 1'b0;
         col_cnt_q <= 4'h0;
      end else begin
         mode_q <= mode_d;
         col_test_q <= col_test_d;
         col_cnt_q <= col_cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // Low-power entry detection
   // ---------------------------------------------------------------
   logic lp_d;

   always_comb begin
      lp_d = lp;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lp_q <= 1'b0;
      end else begin
         lp_q <= lp_d;
      end
   end

   // ---------------------------------------------------------------
   // MAC and line side data paths
   // ---------------------------------------------------------------
   pbmc_mac_rx_t rx_d, rx_q;

   // Loopback returns transmit data as receive data; collision detect is off unless tested.
   // Receive outputs are cleared while the MAC side is silenced or the block is in software reset.
   always_comb begin
      rx_d = line_rx;
      if (lb) begin
         rx_d.rxd = mac_tx.txd;
         rx_d.rx_dv = mac_tx.tx_en;
         rx_d.rx_er = mac_tx.tx_er;
         rx_d.crs = mac_tx.tx_en;
         rx_d.col = 1'b0;
      end else if (!mode_q.full_duplex) begin
         // Outside loopback a line collision reaches the MAC in half duplex only.
         rx_d.col = line_rx.col;
      end else begin
         rx_d.col = 1'b0;
      end
      if (ct) begin
         rx_d.col = col_test_q;
      end
      if (lp || iso || state_q == PBMC_SRST) begin
         rx_d = '0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_q <= '0;
      end else begin
         rx_q <= rx_d;
      end
   end

   // ---------------------------------------------------------------
   // Pin and status outputs
   // ---------------------------------------------------------------
   assign mac_rx = rx_q;
   // Output enable low means the MAC-facing pins float.
   assign mac_out_en = !iso;
   assign mac_tx_clk = mac_silent(ctrl_q) ? 1'b0 : line_tx_clk;
   assign mac_rx_clk = mac_silent(ctrl_q) ? 1'b0 : (lb ? line_tx_clk : line_rx_clk);
   assign line_tx = (mac_silent(ctrl_q) || lb) ? '0 : mac_tx;
   assign pair_transmit_tristate = pair_off(ctrl_q);
   assign pair_receive_enable = !pair_off(ctrl_q);
   // One pulse on entry into low power clears latching status elsewhere.
   assign latch_clear = lp && !lp_q;
   assign soft_reset_active = (state_q == PBMC_SRST);
   // Restart requests are withheld in low power, where negotiation is stopped.
   assign neg_restart = ctrl_q[BIT_NEG_RESTART] && mode_q.neg_enable && !lp;
   assign mode = mode_q;
   // Status reports the resolved rate and duplex of the active mode.
   assign link_status = {mode_q.speed_100, mode_q.full_duplex};
   // Reserved bits read as zero whatever was written.
   assign reg_rdata = ctrl_q & WRITABLE_MASK;
endmodule

// >>> include/pbmc_pkg.sv
package pbmc_pkg;
   localparam int PBMC_W = 16;
   localparam int BIT_SOFT_RESET = 15;
   localparam int BIT_LOOPBACK = 14;
   localparam int BIT_RATE = 13;
   localparam int BIT_NEG_EN = 12;
   localparam int BIT_LOW_POWER = 11;
   localparam int BIT_ISOLATE = 10;
   localparam int BIT_NEG_RESTART = 9;
   localparam int BIT_DUPLEX = 8;
   localparam int BIT_COL_TEST = 7;
   localparam logic [15:0] WRITABLE_MASK = 16'hFF80;
   localparam logic [15:0] RESET_VALUE = 16'h3000;
   localparam logic [4:0] ADDR_ISOLATE_DEFAULT = 5'h00;
   localparam int CLK_MHZ = 200;
   localparam int BIT_NS_10M = 100;
   localparam int BIT_NS_100M = 10;
   localparam int COL_ASSERT_BITS = 512;
   localparam int COL_DEASSERT_BITS = 4;
   localparam int SOFT_RESET_NS = 50;
   localparam logic [3:0] SOFT_RESET_CYCLES = 4'((SOFT_RESET_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] COL_ASSERT_CYCLES = 4'h2;
   localparam logic [3:0] COL_DEASSERT_CYCLES = 4'h1;

   typedef struct packed {
      logic [3:0] txd;
      logic tx_en;
      logic tx_er;
   } pbmc_mac_tx_t;

   typedef struct packed {
      logic [3:0] rxd;
      logic rx_dv;
      logic rx_er;
      logic col;
      logic crs;
   } pbmc_mac_rx_t;

   typedef struct packed {
      logic speed_100;
      logic full_duplex;
      logic neg_enable;
   } pbmc_mode_t;

   typedef enum logic [1:0] {
      PBMC_RUN = 2'b00,
      PBMC_SRST = 2'b01
   } pbmc_state_t;
endpackage

// >>> tb/pbmc_control_properties.sv
`timescale 1ns/100ps
module pbmc_control_properties
   import pbmc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic strap_config_source_pin,
   input wire logic speed_strap_pin,
   input wire logic negotiation_strap_pin,
   input wire logic duplex_strap_pin,
   input wire logic [15:0] reg_rdata,
   input wire logic neg_speed_100,
   input wire logic neg_full_duplex,
   input wire logic neg_started,
   input wire pbmc_pkg::pbmc_mac_rx_t mac_rx,
   input wire logic mac_out_en,
   input wire logic pair_transmit_tristate,
   input wire logic soft_reset_active,
   input wire pbmc_pkg::pbmc_mode_t mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire logic [15:0] r = reg_rdata;
   wire logic sw = strap_config_source_pin & !soft_reset_active & !r[11] & !r[14];
   wire logic hw = !strap_config_source_pin & !soft_reset_active & !r[14];
   AST_RESERVED: assert property (r[6:0] == 7'h00) else $error("reserved bits set");
   AST_HW_MODE: assert property (hw && !negotiation_strap_pin |=>
      mode == {$past(speed_strap_pin), $past(duplex_strap_pin), 1'h0}) else $error("strap mode wrong");
   AST_SW_FIXED: assert property (sw && !r[12] |=>
      mode == {$past(r[13]), $past(r[8]), 1'h0}) else $error("fixed mode wrong");
   AST_SW_NEG: assert property (sw && r[12] |=>
      mode == {$past(neg_speed_100), $past(neg_full_duplex), 1'h1}) else $error("negotiated mode wrong");
   AST_LOOP_DUPLEX: assert property (r[14] |=> !mode.full_duplex) else $error("duplex in loopback");
   AST_ISOLATE: assert property (r[10] [*2] |-> !mac_out_en) else $error("mac side driven");
   AST_LOW_POWER: assert property (r[11] [*3] |-> pair_transmit_tristate && mac_rx == '0) else $error("low power");
   AST_RESTART_OFF: assert property (!r[12] |-> !r[9]) else $error("restart kept");
   AST_RESTART_CLEAR: assert property (neg_started |=> !r[9]) else $error("restart not cleared");
   AST_SOFT_RESET: assert property ($rose(soft_reset_active) |-> soft_reset_active [*8] ##[1:4]
      (!soft_reset_active && r[15:11] == 5'h06)) else $error("soft reset wrong");
   cover property ($rose(soft_reset_active));
   cover property (r[10] && !mac_out_en);
   cover property ($rose(mac_rx.col));
endmodule
bind pbmc_control pbmc_control_properties pbmc_control_properties_i (.*);

// >>> tb/pbmc_partner.sv
`timescale 1ns/100ps
module pbmc_partner #(
   parameter int DELAY = 6
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic neg_restart,
   output logic neg_started,
   output logic neg_speed_100,
   output logic neg_full_duplex
);
   int cnt_q;
   assign neg_speed_100 = 1'h1;
   assign neg_full_duplex = 1'h1;
   // A restart request is answered by a one-cycle start pulse after DELAY+1 cycles.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 0;
         neg_started <= 1'h0;
      end else begin
         neg_started <= cnt_q == DELAY;
         cnt_q <= (neg_restart && cnt_q < DELAY) ? cnt_q + 1 : 0;
      end
   end
endmodule

// >>> tb/pbmc_control_tb.sv
`timescale 1ns/100ps
module pbmc_control_tb;
   import pbmc_pkg::*;
   logic mclk = 0, reset_n = 0, strap_config_source_pin = 1, speed_strap_pin = 0, negotiation_strap_pin = 0;
   logic duplex_strap_pin = 0, reg_wr = 0, neg_speed_100, neg_full_duplex, neg_started, neg_restart;
   logic mac_out_en, pair_transmit_tristate, soft_reset_active;
   logic pair_receive_enable, latch_clear, mac_tx_clk, mac_rx_clk;
   logic [15:0] reg_wdata = '0, reg_rdata;
   logic [1:0] link_status;
   pbmc_mac_tx_t mac_tx = '0, line_tx;
   pbmc_mac_rx_t mac_rx;
   pbmc_mode_t mode;
   int n_mismatch = 0, n_tests = 0, n_latch = 0;
   always #2.5 mclk = !mclk;
   always @(posedge mclk) begin
      if (latch_clear === 1'h1) begin
         n_latch++;
      end
   end
   pbmc_control pbmc_control_i (.mclk, .reset_n, .phy_addr(5'h00), .strap_config_source_pin, .speed_strap_pin,
      .negotiation_strap_pin, .duplex_strap_pin, .reg_wr, .reg_wdata, .reg_rdata, .neg_speed_100,
      .neg_full_duplex, .neg_started, .neg_restart, .mac_tx, .line_rx('0), .line_tx_clk(mclk),
      .line_rx_clk(mclk), .mac_rx, .mac_tx_clk, .mac_rx_clk, .mac_out_en, .line_tx,
      .pair_transmit_tristate, .pair_receive_enable, .latch_clear, .soft_reset_active, .mode, .link_status);
   pbmc_partner pbmc_partner_i (.mclk, .reset_n, .neg_restart, .neg_started, .neg_speed_100, .neg_full_duplex);
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wr(logic [15:0] d);
      @(negedge mclk);
      reg_wr = 1;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 0;
      repeat (3) @(negedge mclk);
   endtask
   task automatic bound(logic c);
      chk("wait", 1'h1, c);
      if (c !== 1'h1) report_and_stop();
   endtask
   task automatic t_restart;
      int i;
      wr(16'h1000);
      wr(16'h1200);
      chk("ctrl", 16'h1200, reg_rdata);
      for (i = 0; i < 20 && reg_rdata[9] !== 1'h0; i++) @(negedge mclk);
      bound(!reg_rdata[9]);
      chk("mode", 3'h7, mode);
   endtask
   task automatic t_col(logic [15:0] d, logic e);
      wr(d);
      mac_tx.tx_en = 1;
      @(posedge mclk);
      #1;
      chk("tx_clk", 1'h1, mac_tx_clk);
      chk("rx_clk", 1'h1, mac_rx_clk);
      repeat (6) @(negedge mclk);
      chk("col", e, mac_rx.col);
      chk("rx_dv", d[14], mac_rx.rx_dv);
      chk("line_tx", d[14] ? 6'h00 : 6'h02, line_tx);
      chk("rx_en", !d[14], pair_receive_enable);
      mac_tx.tx_en = 0;
      repeat (3) @(negedge mclk);
      chk("col", 1'h0, mac_rx.col);
   endtask
   task automatic t_srst;
      int i;
      wr(16'h8000);
      wr(16'h0100);
      for (i = 0; i < 20 && soft_reset_active !== 1'h0; i++) @(negedge mclk);
      bound(!soft_reset_active);
      chk("ctrl", 16'h3400, reg_rdata);
   endtask
   task automatic report_and_stop;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge mclk);
      reset_n = 1;
      repeat (3) @(negedge mclk);
      chk("ctrl", 16'h3400, reg_rdata);
      chk("out_en", 1'h0, mac_out_en);
      wr(16'h2FFF);
      chk("ctrl", 16'h2D80, reg_rdata);
      chk("tristate", 1'h1, pair_transmit_tristate);
      chk("rx_en", 1'h0, pair_receive_enable);
      chk("mac_rx", 8'h00, mac_rx);
      chk("line_tx", 6'h00, line_tx);
      chk("latch", 16'h0001, 16'(n_latch));
      t_restart();
      strap_config_source_pin = 0;
      speed_strap_pin = 1;
      duplex_strap_pin = 1;
      wr(16'h0000);
      chk("ctrl", 16'h0000, reg_rdata);
      chk("mode", 3'h6, mode);
      chk("link", 2'h3, link_status);
      strap_config_source_pin = 1;
      wr(16'h2100);
      chk("mode", 3'h6, mode);
      wr(16'h4100);
      chk("mode", 3'h0, mode);
      t_col(16'h0080, 1'h1);
      t_col(16'h0000, 1'h0);
      t_col(16'h4080, 1'h1);
      t_srst();
      report_and_stop();
   end
endmodule
